// >>> vcap_pkg.sv
/*
 * Shared constants for the video capture port control block: register
 * offset, field positions, reset values and mode encodings.
 * Assumes a single 32-bit memory-mapped control register per block.
 */
package vcap_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam int REG_ADDR_W = 8;
	localparam logic [REG_ADDR_W-1:0] CAPTURE_PORT_CONTROL_OFFSET = 8'h00;
	localparam logic [31:0] CAPTURE_PORT_CONTROL_RESET = 32'h0000_0000;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int VRED_LSB = 18;
	localparam int HRED_LSB = 16;
	localparam int FMT_LSB = 14;
	localparam int SKIP_LSB = 11;
	localparam int INTERLACE_EN_BIT = 10;
	localparam int DOUBLE_BUF_BIT = 9;
	localparam int MODE_SEL_BIT = 8;
	localparam int FIELD_STAT_BIT = 7;
	localparam int INTERLACE_STAT_BIT = 6;
	localparam int CUR_BUF_BIT = 5;
	localparam int FRAME_STAT_BIT = 4;
	localparam int VSYNC_STAT_BIT = 3;
	localparam int SECOND_BUFFER_BUSY_BUSY_BIT = 2;
	localparam int FIRST_BUFFER_BUSY_BUSY_BIT = 1;
	localparam int CAPTURE_EN_BIT = 0;

	// ----------------------------------------------------------------
	// encodings
	// ----------------------------------------------------------------
	localparam logic [2:0] SKIP_NONE = 3'h0;
	localparam logic [2:0] SKIP_ALTERNATE = 3'h1;
	localparam logic [2:0] SKIP_EVEN = 3'h2;
	localparam logic [2:0] SKIP_ODD = 3'h3;
	localparam logic [2:0] SKIP_CAP2_SKIP1 = 3'h4;
	localparam logic [2:0] SKIP_CAP3_SKIP1 = 3'h5;
	localparam logic [2:0] SKIP_CAP1_SKIP2 = 3'h6;
	localparam logic [2:0] SKIP_CAP1_SKIP3 = 3'h7;

	localparam logic [1:0] RED_NONE = 2'h0;
	localparam logic [1:0] RED_HALF = 2'h1;
	localparam logic [1:0] RED_QUARTER = 2'h2;

	localparam logic [1:0] FMT_YUV = 2'h0;
	localparam logic [1:0] FMT_YUV_SWAP = 2'h1;
	localparam logic [1:0] FMT_RGB_A = 2'h2;
	localparam logic [1:0] FMT_RGB_B = 2'h3;

endpackage

// >>> frame_skip_seq.sv
/*
 * Per-frame capture/skip decision from the three-bit skip pattern.
 * Assumes a one-cycle frame_start pulse at each new frame on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none

module frame_skip_seq
	import vcap_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// control
	input wire logic enable,
	input wire logic frame_start,
	input wire logic [2:0] skip_select,
	// result, valid for the frame just started
	output logic capture_frame
);

	logic [1:0] phase_q;
	logic [1:0] phase_d;
	logic [1:0] period_last;
	logic capture_d;

	// ----------------------------------------------------------------
	// pattern decode
	// ----------------------------------------------------------------
	assign period_last = (skip_select == SKIP_CAP2_SKIP1 || skip_select == SKIP_CAP1_SKIP2)
		? 2'h2 : (skip_select == SKIP_CAP3_SKIP1 || skip_select == SKIP_CAP1_SKIP3)
		? 2'h3 : 2'h1;
	assign phase_d = (phase_q >= period_last) ? 2'h0 : phase_q + 2'h1;

	always_comb begin
		unique case (skip_select)
			SKIP_NONE: capture_d = 1'b1;
			SKIP_ALTERNATE: capture_d = (phase_q == 2'h0);
			SKIP_EVEN: capture_d = phase_q[0];
			SKIP_ODD: capture_d = ~phase_q[0];
			SKIP_CAP2_SKIP1: capture_d = (phase_q != 2'h2);
			SKIP_CAP3_SKIP1: capture_d = (phase_q != 2'h3);
			SKIP_CAP1_SKIP2: capture_d = (phase_q == 2'h0);
			SKIP_CAP1_SKIP3: capture_d = (phase_q == 2'h0);
		endcase
	end

	// frame numbering restarts whenever capture is off, so frame 0 is even
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			phase_q <= 2'h0;
			capture_frame <= 1'b0;
		end else if (!enable) begin
			phase_q <= 2'h0;
			capture_frame <= 1'b0;
		end else if (frame_start) begin
			phase_q <= phase_d;
			capture_frame <= capture_d;
		end
	end

endmodule

`default_nettype wire

// >>> two_entry_buffer.sv
/*
 * Two-entry skid buffer with valid/ready on both sides.
 * Assumes both sides on one clock; outputs come straight from flip-flops.
 */
`timescale 1ns/1ns
`default_nettype none

module two_entry_buffer #(
	parameter int WIDTH = 17
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);

	logic [WIDTH-1:0] spare_q;
	logic spare_valid_q;
	logic push;
	logic pop;

	assign push = in_valid & in_ready;
	assign pop = out_valid & out_ready;

	// full after this edge when both the head and the spare are held
	wire head_moves = ~out_valid | pop;
	wire full_next = head_moves ? (spare_valid_q & push) : (spare_valid_q | push);

	// ----------------------------------------------------------------
	// head and spare entry
	// ----------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_valid <= 1'b0;
			out_data <= '0;
			spare_q <= '0;
			spare_valid_q <= 1'b0;
		end else begin
			if (!out_valid || pop) begin
				out_valid <= spare_valid_q | push;
				out_data <= spare_valid_q ? spare_q : in_data;
				spare_valid_q <= spare_valid_q & push;
				if (spare_valid_q)
					spare_q <= in_data;
			end else if (push) begin
				spare_q <= in_data;
				spare_valid_q <= 1'b1;
			end
		end
	end

	// ready is registered: full means both entries held
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			in_ready <= 1'b0;
		end else begin
			in_ready <= ~full_next;
		end
	end

endmodule

`default_nettype wire

// >>> video_capture_port_control.sv
/*
 * Video capture port control: control/status register, frame skipping,
 * buffer selection, conditional capture busy flags, reduction and byte swap
 * of incoming pixels, and the pin direction control of the video port.
 * Assumes video pins are asynchronous to I_MCLK and that the pixel strobe
 * is slower than a quarter of I_MCLK; the register port is on I_MCLK.
 */
`timescale 1ns/1ns
`default_nettype none

// Summary of operation
// - skip codes 000-011: capture all, alternate, skip even, skip odd frames
// - codes 100/101 capture two or three then skip one; 110/111 inverse
// - interlaced enable sends even field to buffer one, odd to two
// - without interlace, single buffering uses buffer one only; double buffering alternates both
// - mode bit 0 captures continuously, 1 captures gated by busy bits
// - field status reads 0 for even field, 1 for odd
// - interlace status reads 1 when incoming video is interlaced
// - current buffer bit reads 0 for buffer one, 1 for buffer two
// - frame status reads 1 when the current frame is captured
// - vsync status reads 1 while the vsync input is active
// - busy bit reads 1 during conditional capture, cleared when it is done, settable by drawing engine
// - continuous capture ignores both busy bits
// - capture enable starts capture and turns port pins except blank into inputs
module video_capture_port_control
	import vcap_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST,
	// memory-mapped register port
	input wire logic I_REG_SEL,
	input wire logic I_REG_WR,
	input wire logic [REG_ADDR_W-1:0] I_REG_ADDR,
	input wire logic [3:0] I_REG_BE,
	input wire logic [31:0] I_REG_WDATA,
	output logic [31:0] O_REG_RDATA,
	// drawing engine busy-bit set pulses, bit 0 = buffer one
	input wire logic [1:0] I_DRAW_SET_BUSY,
	// video port pins
	input wire logic I_VSYNC,
	input wire logic I_HREF,
	input wire logic I_FIELD,
	input wire logic I_PIXEL_STROBE,
	input wire logic [DATA_W-1:0] I_PIXEL_DATA,
	output logic O_VPORT_OE,
	output logic O_BLANK_OE,
	// captured pixel stream
	output logic O_CAP_VALID,
	input wire logic I_CAP_READY,
	output logic [DATA_W-1:0] O_CAP_DATA,
	output logic O_CAP_BUFFER
);

	if (DATA_W != 16) begin : g_width_check
		$error("DATA_W must be 16 for the byte swap format");
	end

	// the reduction field is the highest writable field of the map
	if (VRED_LSB + 2 > 32) begin : g_map_check
		$error("control fields do not fit the 32-bit register");
	end

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	localparam int PIN_W = DATA_W + 4;
	logic [PIN_W-1:0] pin_meta_q;
	logic [PIN_W-1:0] pin_sync_q;
	logic [2:0] edge_q;
	logic vsync_s;
	logic href_s;
	logic field_s;
	logic strobe_s;
	logic [DATA_W-1:0] pixel_s;

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			pin_meta_q <= '0;
			pin_sync_q <= '0;
			edge_q <= 3'h0;
		end else begin
			pin_meta_q <= {I_VSYNC, I_HREF, I_FIELD, I_PIXEL_STROBE, I_PIXEL_DATA};
			pin_sync_q <= pin_meta_q;
			edge_q <= {vsync_s, href_s, strobe_s};
		end
	end

	assign {vsync_s, href_s, field_s, strobe_s, pixel_s} = pin_sync_q;

	wire frame_start = vsync_s & ~edge_q[2];
	wire line_end = ~href_s & edge_q[1];
	wire pixel_tick = strobe_s & ~edge_q[0] & href_s;

	// ----------------------------------------------------------------
	// control register
	// ----------------------------------------------------------------
	logic [1:0] vred_q;
	logic [1:0] hred_q;
	logic [1:0] fmt_q;
	logic [2:0] skip_q;
	logic interlace_en_q;
	logic double_buf_q;
	logic mode_cond_q;
	logic capture_en_q;
	logic [1:0] busy_q;
	logic [1:0] busy_d;
	logic field_q;
	logic interlace_stat_q;
	logic last_field_q;
	logic cur_buf_q;
	logic frame_active_q;
	logic capture_frame;

	wire reg_hit = I_REG_SEL & (I_REG_ADDR == CAPTURE_PORT_CONTROL_OFFSET);
	wire reg_wr = reg_hit & I_REG_WR;
	wire wr_b0 = reg_wr & I_REG_BE[0];
	wire wr_b1 = reg_wr & I_REG_BE[1];
	wire wr_b2 = reg_wr & I_REG_BE[2];
	// write fields, each taken only under the byte enable of its lane
	wire [1:0] wr_vred = I_REG_WDATA[VRED_LSB+:2];
	wire [1:0] wr_hred = I_REG_WDATA[HRED_LSB+:2];
	wire [1:0] wr_fmt = I_REG_WDATA[FMT_LSB+:2];
	wire [2:0] wr_skip = I_REG_WDATA[SKIP_LSB+:3];
	wire [1:0] wr_busy = I_REG_WDATA[SECOND_BUFFER_BUSY_BUSY_BIT:FIRST_BUFFER_BUSY_BUSY_BIT];

	// read-only status, bits 7:3; vsync is the synced pin, not a latched copy
	wire [4:0] status_bits = {field_q, interlace_stat_q, cur_buf_q, frame_active_q,
		vsync_s};
	wire [31:0] readback = {12'h000, vred_q, hred_q, fmt_q, skip_q, interlace_en_q,
		double_buf_q, mode_cond_q, status_bits, busy_q, capture_en_q};
	wire [31:0] rdata_d = reg_hit ? readback : 32'h0000_0000;

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			{vred_q, hred_q} <= CAPTURE_PORT_CONTROL_RESET[19:16];
			fmt_q <= CAPTURE_PORT_CONTROL_RESET[15:14];
			skip_q <= CAPTURE_PORT_CONTROL_RESET[13:11];
			{interlace_en_q, double_buf_q, mode_cond_q} <= CAPTURE_PORT_CONTROL_RESET[10:8];
			capture_en_q <= CAPTURE_PORT_CONTROL_RESET[CAPTURE_EN_BIT];
		end else begin
			if (wr_b2) begin
				vred_q <= wr_vred;
				hred_q <= wr_hred;
			end
			if (wr_b1) begin
				fmt_q <= wr_fmt;
				skip_q <= wr_skip;
				interlace_en_q <= I_REG_WDATA[INTERLACE_EN_BIT];
				double_buf_q <= I_REG_WDATA[DOUBLE_BUF_BIT];
				mode_cond_q <= I_REG_WDATA[MODE_SEL_BIT];
			end
			if (wr_b0)
				capture_en_q <= I_REG_WDATA[CAPTURE_EN_BIT];
		end
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			O_REG_RDATA <= 32'h0000_0000;
		else
			O_REG_RDATA <= rdata_d;
	end

	// ----------------------------------------------------------------
	// busy flags
	// ----------------------------------------------------------------
	// a capture in conditional mode that completes releases the buffer it filled; a software
	// or drawing engine set in the same cycle wins so no new frame is lost
	wire done_now = frame_start & frame_active_q & mode_cond_q;
	genvar b;
	for (b = 0; b < 2; b++) begin : g_busy
		wire sw_set = wr_b0 & wr_busy[b];
		wire sw_clr = wr_b0 & ~wr_busy[b];
		wire hw_clr = done_now & (cur_buf_q == 1'(b));
		assign busy_d[b] = sw_set | I_DRAW_SET_BUSY[b] | (busy_q[b] & ~sw_clr & ~hw_clr);
	end

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			busy_q <= CAPTURE_PORT_CONTROL_RESET[SECOND_BUFFER_BUSY_BUSY_BIT:FIRST_BUFFER_BUSY_BUSY_BIT];
		else
			busy_q <= busy_d;
	end

	// ----------------------------------------------------------------
	// frame sequencing
	// ----------------------------------------------------------------
	frame_skip_seq u_skip (
		.clk(I_MCLK),
		.rst(I_RST),
		.enable(capture_en_q),
		.frame_start(frame_start),
		.skip_select(skip_q),
		.capture_frame(capture_frame)
	);

	// buffer for the next frame: by field when interlaced, else alternating
	// with double buffering, else always buffer one
	wire next_buf = interlace_en_q ? field_q
		: double_buf_q ? ~cur_buf_q : 1'b0;
	// decision is taken one cycle after frame_start, once the skip result lands;
	// the buffer moves with it, so a frame's buffer and its busy test agree
	// and the first frame after enable already follows the field pin
	logic decide_q;
	wire cond_ok = ~mode_cond_q | busy_q[next_buf];

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			decide_q <= 1'b0;
			cur_buf_q <= 1'b0;
			frame_active_q <= 1'b0;
			field_q <= 1'b0;
			last_field_q <= 1'b0;
			interlace_stat_q <= 1'b0;
		end else begin
			decide_q <= frame_start & capture_en_q;
			if (frame_start) begin
				field_q <= field_s;
				last_field_q <= field_s;
				interlace_stat_q <= field_s ^ last_field_q;
			end
			if (!capture_en_q) begin
				frame_active_q <= 1'b0;
			end else if (decide_q) begin
				frame_active_q <= capture_frame & cond_ok;
				if (capture_frame && cond_ok)
					cur_buf_q <= next_buf;
			end
		end
	end

	// ----------------------------------------------------------------
	// reduction and format
	// ----------------------------------------------------------------
	logic [1:0] hcount_q;
	logic [1:0] vcount_q;

	function automatic logic keep_sample(input logic [1:0] sel, input logic [1:0] cnt);
		keep_sample = (sel == RED_HALF) ? (cnt[0] == 1'b0)
			: (sel == RED_QUARTER) ? (cnt == 2'h0) : 1'b1;
	endfunction

	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			hcount_q <= 2'h0;
			vcount_q <= 2'h0;
		end else begin
			if (frame_start)
				vcount_q <= 2'h0;
			else if (line_end)
				vcount_q <= vcount_q + 2'h1;
			if (line_end)
				hcount_q <= 2'h0;
			else if (pixel_tick)
				hcount_q <= hcount_q + 2'h1;
		end
	end

	wire keep_pixel = keep_sample(hred_q, hcount_q) & keep_sample(vred_q, vcount_q);
	wire [DATA_W-1:0] fmt_pixel = (fmt_q == FMT_YUV_SWAP)
		? {pixel_s[7:0], pixel_s[DATA_W-1:8]} : pixel_s;
	wire push_valid = pixel_tick & keep_pixel & frame_active_q & ~decide_q;
	logic fill_ready;

	// the port cannot be stalled: a pixel offered while both entries are held
	// is dropped, so the drain side must keep up on average
	two_entry_buffer #(
		.WIDTH(DATA_W + 1)
	) u_buf (
		.clk(I_MCLK),
		.rst(I_RST),
		.in_valid(push_valid & fill_ready),
		.in_ready(fill_ready),
		.in_data({cur_buf_q, fmt_pixel}),
		.out_valid(O_CAP_VALID),
		.out_ready(I_CAP_READY),
		.out_data({O_CAP_BUFFER, O_CAP_DATA})
	);

	// ----------------------------------------------------------------
	// pin direction
	// ----------------------------------------------------------------
	// blank stays driven whichever way the port runs; only capture pins turn
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST) begin
			O_VPORT_OE <= 1'b1;
			O_BLANK_OE <= 1'b1;
		end else begin
			O_VPORT_OE <= ~capture_en_q;
			O_BLANK_OE <= 1'b1;
		end
	end

endmodule

`default_nettype wire

// >>> vcap_chk.sv
/* Concurrent checks on the video capture port control top-level ports.
   Assumes one clock domain and binding onto every instance of the block. */
`timescale 1ns/1ns
`default_nettype none
module vcap_chk
	import vcap_pkg::*;
#(
	parameter int DATA_W = 16
) (
	// clock and reset
	input wire logic I_MCLK,
	input wire logic I_RST,
	// register port
	input wire logic I_REG_SEL,
	input wire logic I_REG_WR,
	input wire logic [REG_ADDR_W-1:0] I_REG_ADDR,
	input wire logic [3:0] I_REG_BE,
	input wire logic [31:0] I_REG_WDATA,
	input wire logic [31:0] O_REG_RDATA,
	// drawing engine and video pins
	input wire logic [1:0] I_DRAW_SET_BUSY,
	input wire logic I_VSYNC,
	input wire logic I_HREF,
	input wire logic I_FIELD,
	input wire logic I_PIXEL_STROBE,
	input wire logic [DATA_W-1:0] I_PIXEL_DATA,
	input wire logic O_VPORT_OE,
	input wire logic O_BLANK_OE,
	// captured stream
	input wire logic O_CAP_VALID,
	input wire logic I_CAP_READY,
	input wire logic [DATA_W-1:0] O_CAP_DATA,
	input wire logic O_CAP_BUFFER
);
	// ----------------------------------------------------------------
	// helpers and properties
	// ----------------------------------------------------------------
	default clocking @(posedge I_MCLK); endclocking
	default disable iff (I_RST);
	wire hit = I_REG_SEL && I_REG_ADDR == CAPTURE_PORT_CONTROL_OFFSET;
	wire wr0 = hit && I_REG_WR && I_REG_BE[0];
	logic [31:0] wdata_q;
	always_ff @(posedge I_MCLK or posedge I_RST) begin
		if (I_RST)
			wdata_q <= 32'h0000_0000;
		else if (I_REG_SEL && I_REG_WR)
			wdata_q <= I_REG_WDATA;
	end
	sequence s_rd; hit && !I_REG_WR; endsequence
	sequence s_gap_rd; !hit ##1 s_rd; endsequence
	property p_blank_oe; O_BLANK_OE; endproperty
	a_blank_oe: assert property (p_blank_oe) else $error("blank enable low");
	property p_vport_off; wr0 && I_REG_WDATA[0] |-> ##[1:3] !O_VPORT_OE; endproperty
	a_vport_off: assert property (p_vport_off) else $error("pins still driven");
	property p_vport_on; wr0 && !I_REG_WDATA[0] |-> ##[1:3] O_VPORT_OE; endproperty
	a_vport_on: assert property (p_vport_on) else $error("pins not driven");
	property p_vs_hi; I_VSYNC[*6] ##0 s_rd |=> O_REG_RDATA[3]; endproperty
	a_vs_hi: assert property (p_vs_hi) else $error("vsync status low");
	property p_vs_lo; (!I_VSYNC)[*6] ##0 s_rd |=> !O_REG_RDATA[3]; endproperty
	a_vs_lo: assert property (p_vs_lo) else $error("vsync status high");
	property p_readback;
		(hit && I_REG_WR && I_REG_BE == 4'hf) ##1 s_gap_rd |=> O_REG_RDATA[19:8] == wdata_q[19:8];
	endproperty
	a_readback: assert property (p_readback) else $error("field readback");
	property p_dis_status; (wr0 && !I_REG_WDATA[0]) ##1 s_gap_rd |=> !O_REG_RDATA[4]; endproperty
	a_dis_status: assert property (p_dis_status) else $error("frame status set");
	property p_draw_set;
		(!I_VSYNC)[*4] ##0 I_DRAW_SET_BUSY[0] ##1 s_gap_rd |=> O_REG_RDATA[1];
	endproperty
	a_draw_set: assert property (p_draw_set) else $error("busy not set");
endmodule
bind video_capture_port_control vcap_chk #(.DATA_W(DATA_W)) u_vcap_chk (
	.I_MCLK(I_MCLK), .I_RST(I_RST), .I_REG_SEL(I_REG_SEL), .I_REG_WR(I_REG_WR),
	.I_REG_ADDR(I_REG_ADDR), .I_REG_BE(I_REG_BE), .I_REG_WDATA(I_REG_WDATA),
	.O_REG_RDATA(O_REG_RDATA), .I_DRAW_SET_BUSY(I_DRAW_SET_BUSY), .I_VSYNC(I_VSYNC),
	.I_HREF(I_HREF), .I_FIELD(I_FIELD), .I_PIXEL_STROBE(I_PIXEL_STROBE),
	.I_PIXEL_DATA(I_PIXEL_DATA), .O_VPORT_OE(O_VPORT_OE), .O_BLANK_OE(O_BLANK_OE),
	.O_CAP_VALID(O_CAP_VALID), .I_CAP_READY(I_CAP_READY), .O_CAP_DATA(O_CAP_DATA),
	.O_CAP_BUFFER(O_CAP_BUFFER));
`default_nettype wire

// >>> video_source.sv
/* Behavioural video source for the capture port pins.
   Assumes the caller runs one frame at a time on the capture clock. */
`timescale 1ns/1ns
`default_nettype none
module video_source (
	// clock
	input wire logic clk,
	// port pins
	output logic vsync,
	output logic href,
	output logic field,
	output logic strobe,
	output logic [15:0] data
);
	// ----------------------------------------------------------------
	// frame generator
	// ----------------------------------------------------------------
	int vs_len = 4;
	initial begin
		vsync = 1'b0;
		href = 1'b0;
		field = 1'b0;
		strobe = 1'b0;
		data = 16'ha5a5;
	end
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// strobe period of nine clocks keeps it below a quarter of the clock
	task automatic frame(input logic f, input int np, input logic [15:0] d0);
		step(1);
		field = f;
		vsync = 1'b1;
		step(vs_len);
		vsync = 1'b0;
		step(6);
		href = 1'b1;
		for (int i = 0; i < np; i++) begin
			data = d0 + i[15:0];
			step(3);
			strobe = 1'b1;
			step(4);
			strobe = 1'b0;
			step(2);
		end
		href = 1'b0;
		// released data must not look like the last pixel
		data = ~data;
		step(8);
	endtask
endmodule
`default_nettype wire

// >>> testbench.sv
/* Self-checking testbench for the video capture port control block.
   Assumes the video source model drives the port and the checker is bound. */
`timescale 1ns/1ns
`default_nettype none
module testbench
	import vcap_pkg::*;
;
	logic clk = 1'b0, rst = 1'b1, sel = 1'b0, wr = 1'b0, rdy = 1'b1;
	logic [REG_ADDR_W-1:0] addr = 8'h00;
	logic [3:0] be = 4'h0;
	logic [31:0] wd = 32'h0000_0000, rdv, r;
	logic [1:0] draw = 2'h0;
	logic vs, hr, fl, st, vp_oe, bl_oe, cv, cb, last_b = 1'b0, pb, pr;
	logic [15:0] pd, cd, e, last_d = 16'h0000, prev_d = 16'h0000;
	int miscompares = 0, tests_run = 0, ncap = 0, base;
	// skip code in 10:8, capture flag per frame number in 7:0
	logic [10:0] skip_rows [8] = '{11'h0ff, 11'h155, 11'h2aa, 11'h355,
		11'h4db, 11'h577, 11'h649, 11'h711};
	// kept pixel count in 4:2, index of the last kept pixel in 1:0
	logic [4:0] hrow [4] = '{5'h13, 5'h0a, 5'h04, 5'h13};
	always #5 clk = ~clk;
	video_source src (.clk(clk), .vsync(vs), .href(hr), .field(fl), .strobe(st), .data(pd));
	video_capture_port_control #(.DATA_W(16)) uut (
		.I_MCLK(clk), .I_RST(rst), .I_REG_SEL(sel), .I_REG_WR(wr), .I_REG_ADDR(addr),
		.I_REG_BE(be), .I_REG_WDATA(wd), .O_REG_RDATA(rdv), .I_DRAW_SET_BUSY(draw),
		.I_VSYNC(vs), .I_HREF(hr), .I_FIELD(fl), .I_PIXEL_STROBE(st), .I_PIXEL_DATA(pd),
		.O_VPORT_OE(vp_oe), .O_BLANK_OE(bl_oe), .O_CAP_VALID(cv), .I_CAP_READY(rdy),
		.O_CAP_DATA(cd), .O_CAP_BUFFER(cb));
	always @(posedge clk) begin
		if (cv === 1'b1 && rdy === 1'b1) begin
			ncap++;
			prev_d = last_d;
			last_d = cd;
			last_b = cb;
		end
	end
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", n, exp, got);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [3:0] b, input logic [31:0] d);
		tick(1);
		sel = 1'b1;
		wr = 1'b1;
		addr = a;
		be = b;
		wd = d;
		tick(1);
		sel = 1'b0;
		wr = 1'b0;
	endtask
	task automatic rreg(input logic [7:0] a, output logic [31:0] d);
		tick(1);
		sel = 1'b1;
		addr = a;
		tick(1);
		sel = 1'b0;
		d = rdv;
	endtask
	task automatic conclude;
		if (miscompares == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	initial begin
		repeat (60000) @(posedge clk);
		miscompares++;
		conclude();
	end
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		tick(12);
		rst = 1'b0;
		chk("blank oe", bl_oe, 1);
		chk("cap valid", cv, 0);
		rreg(0, r);
		chk("ctl reset", r, CAPTURE_PORT_CONTROL_RESET);
		wreg(0, 4'hf, 32'hffff_ffff);
		rreg(0, r);
		chk("ctl rw", r & 32'hffff_ff07, 32'h000f_ff07);
		tick(1);
		chk("port oe on", vp_oe, 0);
		wreg(8'h04, 4'hf, 0);
		rreg(8'h04, r);
		chk("unmapped", r, 0);
		wreg(0, 4'h2, 0);
		rreg(0, r);
		chk("byte lane", r & 32'hffff_ff07, 32'h000f_0007);
		wreg(0, 4'hf, 0);
		rreg(0, r);
		chk("status off", r[4], 0);
		tick(1);
		chk("port oe off", vp_oe, 1);
		foreach (skip_rows[i]) begin
			wreg(0, 4'hf, 0);
			wreg(0, 4'hf, {18'h0, skip_rows[i][10:8], 11'h001});
			for (int n = 0; n < 8; n++) begin
				base = ncap;
				src.frame(1'b0, 1, 16'h1000);
				rreg(0, r);
				chk("skip count", ncap - base, skip_rows[i][n]);
				chk("frame status", r[4], skip_rows[i][n]);
				chk("single buffer", r[5], 0);
			end
		end
		for (int m = 0; m < 2; m++) begin
			wreg(0, 4'hf, 0);
			wreg(0, 4'hf, m ? 32'h0000_0601 : 32'h0000_0201);
			for (int n = 0; n < 4; n++) begin
				pb = last_b;
				src.frame(n[0], 1, 16'h2000);
				rreg(0, r);
				if (m || n > 0) begin
					chk("pixel buffer", last_b, m ? n[0] : !pb);
					chk("cur buffer", r[5], m ? n[0] : !pr);
				end
				pr = r[5];
				chk("field status", r[7], n[0]);
				if (n > 0)
					chk("interlace status", r[6], 1);
			end
		end
		wreg(0, 4'hf, 0);
		wreg(0, 4'hf, 32'h0000_0101);
		base = ncap;
		src.frame(1'b0, 1, 16'h3000);
		chk("gated off", ncap - base, 0);
		draw = 2'h1;
		tick(1);
		draw = 2'h0;
		rreg(0, r);
		chk("draw set", r[1], 1);
		base = ncap;
		src.frame(1'b0, 1, 16'h3001);
		chk("gated on", ncap - base, 1);
		src.frame(1'b0, 0, 16'h0000);
		rreg(0, r);
		chk("busy cleared", r[1], 0);
		wreg(0, 4'h1, 32'h0000_0007);
		base = ncap;
		src.frame(1'b0, 1, 16'h3002);
		chk("soft set", ncap - base, 1);
		for (int h = 0; h < 4; h++) begin
			wreg(0, 4'hf, 0);
			wreg(0, 4'hf, {12'h0, 2'h0, h[1:0], 2'h1, 14'h0001});
			base = ncap;
			src.frame(1'b0, 4, 16'h1234);
			e = 16'h1234 + hrow[h][1:0];
			chk("reduced count", ncap - base, hrow[h][4:2]);
			chk("swapped data", last_d, {e[7:0], e[15:8]});
		end
		wreg(0, 4'hf, 0);
		wreg(0, 4'hf, 32'h0000_0001);
		rdy = 1'b0;
		base = ncap;
		src.frame(1'b0, 2, 16'h0abc);
		chk("stalled", ncap - base, 0);
		rdy = 1'b1;
		tick(4);
		chk("drained", ncap - base, 2);
		chk("first word", prev_d, 16'h0abc);
		chk("second word", last_d, 16'h0abd);
		src.vs_len = 12;
		fork
			src.frame(1'b0, 0, 16'h0000);
			begin
				tick(9);
				rreg(0, r);
			end
		join
		chk("vsync status", r[3], 1);
		rst = 1'b1;
		tick(2);
		rst = 1'b0;
		rreg(0, r);
		chk("ctl after reset", r, CAPTURE_PORT_CONTROL_RESET);
		chk("port oe reset", vp_oe, 1);
		conclude();
	end
endmodule
`default_nettype wire
